// ==== logic/etc_timer.sv ====
// Eight-bit timer with one compare unit, registers behind an AXI4-Lite slave.
// Assumes the interrupt controller returns an acknowledge pulse per executed request.
//
// Function
// - Bottom means count equals 0x00
// - Maximum means count equals 0xFF
// - Top is 0xFF or compare, per mode
// - Counter and compare are CPU-accessible 8-bit registers
// - Flags shown in flag register, masked individually
// - Tick from selected source and edge
// - Clock select zero stops the timer
// - Tick clears, increments or decrements per mode
// - CPU counter write beats clear or count
// - Overflow flag set per mode, can interrupt
// - Continuous compare; flag set on next tick
// - Compare request needs enable and global flag
// - Writing one clears the compare flag
// - Compare double buffered only in PWM modes
// - CPU reaches buffer when buffering, else compare
// - Force strobe acts like match in non-PWM modes only, no flag
// - Counter write blocks matches on next tick
// - Match, max, bottom drive the waveform generator
// - Output state kept across mode changes
// - Output mode bits take effect immediately
// - Output state resets to zero
// - Mode zero counts up, wraps without clear
// - Output mode zero leaves output unchanged
`timescale 1ns/100ps
module etc_timer #(
  parameter int unsigned ADDR_W = etc_pkg::ADDR_W,
  parameter int unsigned DATA_W = etc_pkg::DATA_W,
  parameter int unsigned REG_W  = etc_pkg::REG_W
) (
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              arst_n_i,
  // AXI4-Lite write address
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  // AXI4-Lite write data
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  input  wire logic [DATA_W-1:0] s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  // AXI4-Lite write response
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  output logic [1:0]             s_axi_bresp_o,
  // AXI4-Lite read address
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  // AXI4-Lite read data
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  output logic [DATA_W-1:0]      s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  // Interrupt handshake with the CPU core
  input  wire logic              global_irq_en_i,
  input  wire logic              ovf_irq_ack_i,
  input  wire logic              cmp_irq_ack_i,
  output logic                   ovf_irq_o,
  output logic                   cmp_irq_o,
  // Count pin and compare output
  input  wire logic              ext_count_pin_i,
  output logic                   compare_output_o
);

  typedef struct packed {
    etc_pkg::etc_ctrl_t ctrl;
    logic [REG_W-1:0]   timer_count;
    logic [REG_W-1:0]   compare_value;
    logic [REG_W-1:0]   compare_buf;
    logic               count_down;
    logic               match_block;
    logic               compare_output;
    logic               overflow_flag;
    logic               compare_flag;
    logic               overflow_irq_enable;
    logic               compare_irq_enable;
    logic               ovf_irq;
    logic               cmp_irq;
    logic               awready;
    logic               aw_hold;
    logic [ADDR_W-1:0]  aw_addr;
    logic               wready;
    logic               w_hold;
    logic [REG_W-1:0]   w_data;
    logic               w_lane0;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [REG_W-1:0]   rdata;
    logic [1:0]         rresp;
  } etc_timer_state_t;

  etc_timer_state_t s;
  etc_timer_state_t next_s;
  logic             timer_tick;

  // Word-aligned mapped register check
  function automatic logic addr_ok(input logic [ADDR_W-1:0] addr);
    return (addr == etc_pkg::ADDR_CTRL)  || (addr == etc_pkg::ADDR_COUNT) ||
           (addr == etc_pkg::ADDR_CMP)   || (addr == etc_pkg::ADDR_FLAG)  ||
           (addr == etc_pkg::ADDR_MASK);
  endfunction

  // Non-PWM output action on match or force
  function automatic logic com_action(input etc_pkg::etc_com_t com, input logic oc);
    logic res;
    res = oc;
    unique case (com)
      etc_pkg::COM_OFF:    res = oc;
      etc_pkg::COM_TOGGLE: res = ~oc;
      etc_pkg::COM_CLEAR:  res = 1'b0;
      etc_pkg::COM_SET:    res = 1'b1;
    endcase
    return res;
  endfunction

  function automatic logic is_pwm(input etc_pkg::etc_wave_mode_t wgm);
    return (wgm == etc_pkg::WGM_PHASE_PWM) || (wgm == etc_pkg::WGM_FAST_PWM);
  endfunction

  etc_clock_select u_clock_select (
    .clk_sys_i       (clk_sys_i),
    .arst_n_i        (arst_n_i),
    .clock_select_i  (s.ctrl.cs),
    .ext_count_pin_i (ext_count_pin_i),
    .timer_tick_o    (timer_tick)
  );

  always_comb begin
    logic               wr_go;
    logic               wr_en;
    logic               ctrl_wr;
    logic               count_wr;
    logic               cmp_wr;
    logic               flag_wr;
    logic               mask_wr;
    logic               pwm;
    logic               at_bottom;
    logic               at_max;
    logic               match;
    logic               match_ev;
    logic               force_ev;
    logic               ovf_set;
    logic               cmp_set;
    etc_pkg::etc_ctrl_t wr_ctrl;
    next_s    = s;
    wr_go     = s.aw_hold && s.w_hold && !s.bvalid;
    wr_en     = wr_go && addr_ok(s.aw_addr) && s.w_lane0;
    ctrl_wr   = wr_en && (s.aw_addr == etc_pkg::ADDR_CTRL);
    count_wr  = wr_en && (s.aw_addr == etc_pkg::ADDR_COUNT);
    cmp_wr    = wr_en && (s.aw_addr == etc_pkg::ADDR_CMP);
    flag_wr   = wr_en && (s.aw_addr == etc_pkg::ADDR_FLAG);
    mask_wr   = wr_en && (s.aw_addr == etc_pkg::ADDR_MASK);
    wr_ctrl   = etc_pkg::etc_ctrl_t'(s.w_data);
    pwm       = is_pwm(s.ctrl.wgm);
    at_bottom = (s.timer_count == etc_pkg::COUNT_BOTTOM);
    at_max    = (s.timer_count == etc_pkg::COUNT_MAX);
    match     = (s.timer_count == s.compare_value);
    match_ev  = timer_tick && match && !s.match_block;
    force_ev  = ctrl_wr && wr_ctrl.force_cmp && !is_pwm(wr_ctrl.wgm);
    ovf_set   = 1'b0;
    cmp_set   = match_ev;

    // Bus write channels: address and data taken in either order
    if (s_axi_awvalid_i && s.awready) begin
      next_s.aw_hold = 1'b1;
      next_s.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s.wready) begin
      next_s.w_hold  = 1'b1;
      next_s.w_data  = s_axi_wdata_i[REG_W-1:0];
      next_s.w_lane0 = s_axi_wstrb_i[0];
    end
    if (s.bvalid && s_axi_bready_i) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_s.aw_hold = 1'b0;
      next_s.w_hold  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = addr_ok(s.aw_addr) ? etc_pkg::RESP_OKAY : etc_pkg::RESP_SLVERR;
    end
    next_s.awready = !next_s.aw_hold && !next_s.bvalid;
    next_s.wready  = !next_s.w_hold && !next_s.bvalid;

    // Bus read: one cycle from address to data
    if (s.rvalid && s_axi_rready_i) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = addr_ok(s_axi_araddr_i) ? etc_pkg::RESP_OKAY : etc_pkg::RESP_SLVERR;
      next_s.rdata  = etc_pkg::REG_RESET;
      unique case (s_axi_araddr_i)
        etc_pkg::ADDR_CTRL:  next_s.rdata = s.ctrl;
        etc_pkg::ADDR_COUNT: next_s.rdata = s.timer_count;
        etc_pkg::ADDR_CMP:   next_s.rdata = pwm ? s.compare_buf : s.compare_value;
        etc_pkg::ADDR_FLAG: begin
          next_s.rdata[etc_pkg::OVF_BIT] = s.overflow_flag;
          next_s.rdata[etc_pkg::CMP_BIT] = s.compare_flag;
        end
        etc_pkg::ADDR_MASK: begin
          next_s.rdata[etc_pkg::OVF_BIT] = s.overflow_irq_enable;
          next_s.rdata[etc_pkg::CMP_BIT] = s.compare_irq_enable;
        end
        default: next_s.rdata = etc_pkg::REG_RESET;
      endcase
    end
    next_s.arready = !next_s.rvalid;

    // Control and mask registers
    if (ctrl_wr) begin
      next_s.ctrl           = wr_ctrl;
      next_s.ctrl.force_cmp = 1'b0;
    end
    if (mask_wr) begin
      next_s.overflow_irq_enable = s.w_data[etc_pkg::OVF_BIT];
      next_s.compare_irq_enable  = s.w_data[etc_pkg::CMP_BIT];
    end

    // Compare register, buffered only in PWM modes
    if (cmp_wr) begin
      next_s.compare_buf = s.w_data;
      if (!pwm) begin
        next_s.compare_value = s.w_data;
      end
    end
    if (timer_tick && pwm && at_max) begin
      next_s.compare_value = s.compare_buf;
    end

    // Counter unit
    if (timer_tick) begin
      next_s.match_block = 1'b0;
      unique case (s.ctrl.wgm)
        etc_pkg::WGM_NORMAL: begin
          next_s.timer_count = s.timer_count + etc_pkg::COUNT_STEP;
          ovf_set            = at_max;
          next_s.count_down  = 1'b0;
        end
        etc_pkg::WGM_CTC: begin
          // Top is the compare value
          next_s.timer_count = match_ev ? etc_pkg::COUNT_BOTTOM
                                        : s.timer_count + etc_pkg::COUNT_STEP;
          ovf_set            = at_max;
          next_s.count_down  = 1'b0;
        end
        etc_pkg::WGM_FAST_PWM: begin
          next_s.timer_count = at_max ? etc_pkg::COUNT_BOTTOM
                                      : s.timer_count + etc_pkg::COUNT_STEP;
          ovf_set            = at_max;
          next_s.count_down  = 1'b0;
        end
        etc_pkg::WGM_PHASE_PWM: begin
          // Dual slope: down after top, up again at bottom
          if (!s.count_down && at_max) begin
            next_s.count_down  = 1'b1;
            next_s.timer_count = s.timer_count - etc_pkg::COUNT_STEP;
          end else if (s.count_down && at_bottom) begin
            next_s.count_down  = 1'b0;
            next_s.timer_count = s.timer_count + etc_pkg::COUNT_STEP;
            ovf_set            = 1'b1;
          end else if (s.count_down) begin
            next_s.timer_count = s.timer_count - etc_pkg::COUNT_STEP;
          end else begin
            next_s.timer_count = s.timer_count + etc_pkg::COUNT_STEP;
          end
        end
      endcase
    end
    if (count_wr) begin
      next_s.timer_count = s.w_data;
      next_s.match_block = 1'b1;
    end

    // Waveform generator; output state kept across mode writes
    if (force_ev) begin
      next_s.compare_output = com_action(wr_ctrl.com, s.compare_output);
    end
    if (match_ev) begin
      unique case (s.ctrl.wgm)
        etc_pkg::WGM_NORMAL, etc_pkg::WGM_CTC: begin
          next_s.compare_output = com_action(s.ctrl.com, next_s.compare_output);
        end
        etc_pkg::WGM_FAST_PWM: begin
          if (s.ctrl.com == etc_pkg::COM_CLEAR) begin
            next_s.compare_output = 1'b0;
          end else if (s.ctrl.com == etc_pkg::COM_SET) begin
            next_s.compare_output = 1'b1;
          end
        end
        etc_pkg::WGM_PHASE_PWM: begin
          if (s.ctrl.com == etc_pkg::COM_CLEAR) begin
            next_s.compare_output = s.count_down;
          end else if (s.ctrl.com == etc_pkg::COM_SET) begin
            next_s.compare_output = !s.count_down;
          end
        end
      endcase
    end
    // Fast PWM bottom action wins over a match at max
    if (timer_tick && at_max && (s.ctrl.wgm == etc_pkg::WGM_FAST_PWM)) begin
      if (s.ctrl.com == etc_pkg::COM_CLEAR) begin
        next_s.compare_output = 1'b1;
      end else if (s.ctrl.com == etc_pkg::COM_SET) begin
        next_s.compare_output = 1'b0;
      end
    end

    // Flags: a set in the clearing cycle wins
    next_s.overflow_flag = ovf_set | (s.overflow_flag &
                           !(ovf_irq_ack_i || (flag_wr && s.w_data[etc_pkg::OVF_BIT])));
    next_s.compare_flag  = cmp_set | (s.compare_flag &
                           !(cmp_irq_ack_i || (flag_wr && s.w_data[etc_pkg::CMP_BIT])));
    // Requests gated per bit and by the global flag
    next_s.ovf_irq = next_s.overflow_flag && next_s.overflow_irq_enable && global_irq_en_i;
    next_s.cmp_irq = next_s.compare_flag && next_s.compare_irq_enable && global_irq_en_i;
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s         <= '0;
      s.awready <= 1'b1;
      s.wready  <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready_o  = s.awready;
  assign s_axi_wready_o   = s.wready;
  assign s_axi_bvalid_o   = s.bvalid;
  assign s_axi_bresp_o    = s.bresp;
  assign s_axi_arready_o  = s.arready;
  assign s_axi_rvalid_o   = s.rvalid;
  assign s_axi_rdata_o    = {{(DATA_W-REG_W){1'b0}}, s.rdata};
  assign s_axi_rresp_o    = s.rresp;
  assign ovf_irq_o        = s.ovf_irq;
  assign cmp_irq_o        = s.cmp_irq;
  assign compare_output_o = s.compare_output;

endmodule

// ==== inc/etc_pkg.sv ====
// Shared constants and types of the eight-bit timer with one compare unit.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses on word boundaries.
package etc_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL  = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_CMP   = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_FLAG  = 5'h0C;
  localparam logic [ADDR_W-1:0] ADDR_MASK  = 5'h10;

  // Bit positions in flag and mask registers
  localparam int unsigned OVF_BIT = 0;
  localparam int unsigned CMP_BIT = 1;

  // Counter landmarks and reset values
  localparam logic [REG_W-1:0] COUNT_BOTTOM = 8'h00;
  localparam logic [REG_W-1:0] COUNT_MAX    = 8'hFF;
  localparam logic [REG_W-1:0] COUNT_STEP   = 8'h01;
  localparam logic [REG_W-1:0] REG_RESET    = 8'h00;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Prescaler width and tap masks
  localparam int unsigned PRESC_W = 10;
  localparam logic [PRESC_W-1:0] PRESC_ONE      = 10'h001;
  localparam logic [PRESC_W-1:0] TAP_DIV8       = 10'h007;
  localparam logic [PRESC_W-1:0] TAP_DIV64      = 10'h03F;
  localparam logic [PRESC_W-1:0] TAP_DIV256     = 10'h0FF;
  localparam logic [PRESC_W-1:0] TAP_DIV1024    = 10'h3FF;

  typedef enum logic [2:0] {
    CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
  } etc_clk_sel_t;

  typedef enum logic [1:0] {
    WGM_NORMAL, WGM_PHASE_PWM, WGM_CTC, WGM_FAST_PWM
  } etc_wave_mode_t;

  typedef enum logic [1:0] {
    COM_OFF, COM_TOGGLE, COM_CLEAR, COM_SET
  } etc_com_t;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic           force_cmp;
    etc_com_t       com;
    etc_wave_mode_t wgm;
    etc_clk_sel_t   cs;
  } etc_ctrl_t;

endpackage

// ==== logic/etc_clock_select.sv ====
// Clock select: free prescaler and external pin edge detector giving the timer tick.
// Assumes ext_count_pin_i is asynchronous to clk_sys_i.
`timescale 1ns/100ps
module etc_clock_select #(
  parameter int unsigned PRESC_W = etc_pkg::PRESC_W
) (
  // Clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 arst_n_i,
  // Selection and pin
  input  wire etc_pkg::etc_clk_sel_t clock_select_i,
  input  wire logic                 ext_count_pin_i,
  // Tick out
  output logic                      timer_tick_o
);

  typedef struct packed {
    logic [PRESC_W-1:0] presc;
    logic               pin_meta;
    logic               pin_sync;
    logic               pin_prev;
    logic               tick;
  } etc_cs_state_t;

  etc_cs_state_t s;
  etc_cs_state_t next_s;

  function automatic logic tap_hit(input logic [PRESC_W-1:0] cnt,
                                   input logic [PRESC_W-1:0] mask);
    return (cnt & mask) == mask;
  endfunction

  always_comb begin
    next_s          = s;
    next_s.presc    = s.presc + PRESC_W'(etc_pkg::PRESC_ONE);
    next_s.pin_meta = ext_count_pin_i;
    next_s.pin_sync = s.pin_meta;
    next_s.pin_prev = s.pin_sync;
    // Source and edge picked by the select field; zero gives no tick
    unique case (clock_select_i)
      etc_pkg::CS_STOP:     next_s.tick = 1'b0;
      etc_pkg::CS_DIV1:     next_s.tick = 1'b1;
      etc_pkg::CS_DIV8:     next_s.tick = tap_hit(s.presc, PRESC_W'(etc_pkg::TAP_DIV8));
      etc_pkg::CS_DIV64:    next_s.tick = tap_hit(s.presc, PRESC_W'(etc_pkg::TAP_DIV64));
      etc_pkg::CS_DIV256:   next_s.tick = tap_hit(s.presc, PRESC_W'(etc_pkg::TAP_DIV256));
      etc_pkg::CS_DIV1024:  next_s.tick = tap_hit(s.presc, PRESC_W'(etc_pkg::TAP_DIV1024));
      etc_pkg::CS_EXT_FALL: next_s.tick = s.pin_prev & ~s.pin_sync;
      etc_pkg::CS_EXT_RISE: next_s.tick = s.pin_sync & ~s.pin_prev;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign timer_tick_o = s.tick;

endmodule

// ==== sim/etc_timer_sva.sv ====
// Checker for bus handshakes, response codes and interrupt gating of the timer.
// Assumes it is bound to etc_timer and sees only that module's ports.
`timescale 1ns/100ps
module etc_timer_sva #(
  parameter int unsigned ADDR_W = etc_pkg::ADDR_W,
  parameter int unsigned DATA_W = etc_pkg::DATA_W
) (
  // Clock and reset
  input wire logic              clk_sys_i,
  input wire logic              arst_n_i,
  // Write channels
  input wire logic              s_axi_awvalid_i,
  input wire logic              s_axi_awready_o,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic              s_axi_wvalid_i,
  input wire logic              s_axi_wready_o,
  input wire logic              s_axi_bvalid_o,
  input wire logic              s_axi_bready_i,
  input wire logic [1:0]        s_axi_bresp_o,
  // Read channels
  input wire logic              s_axi_arvalid_i,
  input wire logic              s_axi_arready_o,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic              s_axi_rvalid_o,
  input wire logic              s_axi_rready_i,
  input wire logic [DATA_W-1:0] s_axi_rdata_o,
  input wire logic [1:0]        s_axi_rresp_o,
  // Interrupts
  input wire logic              global_irq_en_i,
  input wire logic              ovf_irq_o,
  input wire logic              cmp_irq_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  function automatic logic [1:0] resp_of(input logic [ADDR_W-1:0] a);
    if (a > etc_pkg::ADDR_MASK || a[1:0] != 2'h0) return etc_pkg::RESP_SLVERR;
    return etc_pkg::RESP_OKAY;
  endfunction

  sequence wr_both;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence rd_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence

  a_write_resp: assert property (wr_both |=> ##1 s_axi_bvalid_o &&
    s_axi_bresp_o == resp_of($past(s_axi_awaddr_i, 2))) else $error("bad write response");
  a_read_resp: assert property (rd_taken |=> s_axi_rvalid_o &&
    s_axi_rresp_o == resp_of($past(s_axi_araddr_i))) else $error("bad read response");
  a_read_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
  a_write_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
  a_write_busy: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write ready while response pending");
  a_read_busy: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read ready while data pending");
  a_rdata_byte: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[DATA_W-1:8] == '0)
    else $error("read data wider than a byte");
  a_cmp_irq_gate: assert property (!$past(global_irq_en_i) |-> !cmp_irq_o)
    else $error("compare request without global enable");
  a_ovf_irq_gate: assert property (!$past(global_irq_en_i) |-> !ovf_irq_o)
    else $error("overflow request without global enable");
endmodule

bind etc_timer etc_timer_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_sva (
  .clk_sys_i, .arst_n_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_awaddr_i,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_araddr_i, .s_axi_rvalid_o, .s_axi_rready_i,
  .s_axi_rdata_o, .s_axi_rresp_o, .global_irq_en_i, .ovf_irq_o, .cmp_irq_o
);

// ==== sim/etc_cpu_model.sv ====
// Far side of the timer: interrupt acknowledge of the core and the count pin source.
// Assumes one clock shared with the timer; pulse is called from the testbench.
`timescale 1ns/100ps
module etc_cpu_model (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  // Interrupt handshake
  input  wire logic ovf_irq_i,
  input  wire logic cmp_irq_i,
  output logic      ovf_irq_ack_o,
  output logic      cmp_irq_ack_o,
  // Count pin
  output logic      ext_count_pin_o
);
  int unsigned acks;
  logic        ovf_q;
  logic        cmp_q;

  initial begin
    ext_count_pin_o = 1'b0;
    acks = 0;
  end

  // One handler run per raised request
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {ovf_q, cmp_q, ovf_irq_ack_o, cmp_irq_ack_o} <= 4'h0;
    end else begin
      ovf_q <= ovf_irq_i;
      cmp_q <= cmp_irq_i;
      ovf_irq_ack_o <= ovf_irq_i && !ovf_q;
      cmp_irq_ack_o <= cmp_irq_i && !cmp_q;
      acks <= acks + 32'(ovf_irq_ack_o) + 32'(cmp_irq_ack_o);
    end
  end

  // Slow pin pulses so the synchroniser sees each edge
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (6) @(posedge clk_sys_i);
      ext_count_pin_o <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      ext_count_pin_o <= 1'b0;
    end
    repeat (8) @(posedge clk_sys_i);
  endtask
endmodule

// ==== sim/eight_bit_timer_compare_unit_test.sv ====
// Self-checking bench of the timer through its AXI4-Lite registers.
// Assumes etc_cpu_model drives the count pin and answers interrupts.
`timescale 1ns/100ps
module eight_bit_timer_compare_unit_test;
  localparam logic [4:0] CT = etc_pkg::ADDR_CTRL, CN = etc_pkg::ADDR_COUNT,
                         CM = etc_pkg::ADDR_CMP, FL = etc_pkg::ADDR_FLAG, MK = etc_pkg::ADDR_MASK;
  localparam logic [1:0] OK = etc_pkg::RESP_OKAY, SE = etc_pkg::RESP_SLVERR;
  logic        clk_sys_i, arst_n_i, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, glb, oack, cack, pin, oirq, cirq, cout;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb;
  int          fails, checks;

  etc_timer DUT (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_araddr_i(araddr),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .global_irq_en_i(glb), .ovf_irq_ack_i(oack),
    .cmp_irq_ack_i(cack), .ovf_irq_o(oirq), .cmp_irq_o(cirq),
    .ext_count_pin_i(pin), .compare_output_o(cout));
  etc_cpu_model CPU (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ovf_irq_i(oirq),
    .cmp_irq_i(cirq), .ovf_irq_ack_o(oack), .cmp_irq_ack_o(cack), .ext_count_pin_o(pin));

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    checks++;
    if (got !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge clk_sys_i);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h000000, d};
    bready <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk("bresp", {30'h0, r}, {30'h0, bresp});
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [1:0] r);
    @(posedge clk_sys_i);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk("rdata", {24'h000000, e}, rdata);
    chk("rresp", {30'h0, r}, {30'h0, rresp});
    rready <= 1'b0;
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fails++;
    report_and_stop;
  end

  initial begin
    logic [7:0] fv[7];
    logic       ev[7];
    fv = '{8'hA0, 8'hC0, 8'hE0, 8'h80, 8'hB0, 8'h18, 8'hF8};
    ev = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    {awvalid, wvalid, bready, arvalid, rready, glb} = 6'h00;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    fails = 0;
    checks = 0;
    arst_n_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    chk("cmp_out", 32'h0, {31'h0, cout});
    for (int i = 0; i < 5; i++) rd(5'(4 * i), 8'h00, OK);
    rd(5'h14, 8'h00, SE);
    rd(5'h02, 8'h00, SE);
    wr(5'h18, 8'hFF, SE);
    wstrb <= 4'hE;
    wr(CN, 8'h77, OK);
    wstrb <= 4'hF;
    rd(CN, 8'h00, OK);
    done("reset and map");
    wr(CN, 8'h5A, OK);
    repeat (20) @(posedge clk_sys_i);
    rd(CN, 8'h5A, OK);
    done("stopped");
    for (int i = 0; i < 7; i++) begin
      wr(CT, fv[i], OK);
      repeat (2) @(posedge clk_sys_i);
      chk("cmp_out", {31'h0, ev[i]}, {31'h0, cout});
    end
    rd(FL, 8'h00, OK);
    done("force");
    wr(CT, 8'h00, OK);
    wr(CM, 8'h20, OK);
    wr(CN, 8'h20, OK);
    wr(CT, 8'h07, OK);
    CPU.pulse(1);
    rd(CN, 8'h21, OK);
    rd(FL, 8'h00, OK);
    wr(CN, 8'h1F, OK);
    CPU.pulse(2);
    rd(CN, 8'h21, OK);
    rd(FL, 8'h02, OK);
    wr(FL, 8'h02, OK);
    rd(FL, 8'h00, OK);
    done("match");
    wr(CN, 8'hFE, OK);
    CPU.pulse(2);
    rd(CN, 8'h00, OK);
    rd(FL, 8'h01, OK);
    wr(FL, 8'h01, OK);
    done("overflow");
    wr(MK, 8'h02, OK);
    wr(CN, 8'h1F, OK);
    CPU.pulse(2);
    wr(CN, 8'hFE, OK);
    CPU.pulse(2);
    chk("cmp_irq", 32'h0, {31'h0, cirq});
    rd(FL, 8'h03, OK);
    glb <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    chk("ovf_irq", 32'h0, {31'h0, oirq});
    rd(FL, 8'h01, OK);
    chk("acks", 32'h1, CPU.acks);
    wr(MK, 8'h03, OK);
    rd(FL, 8'h00, OK);
    chk("acks", 32'h2, CPU.acks);
    glb <= 1'b0;
    done("interrupt");
    wr(CT, 8'h1F, OK);
    wr(CM, 8'h40, OK);
    rd(CM, 8'h40, OK);
    wr(CN, 8'h1F, OK);
    CPU.pulse(2);
    rd(FL, 8'h02, OK);
    chk("cmp_out", 32'h0, {31'h0, cout});
    wr(FL, 8'h02, OK);
    wr(CT, 8'h0F, OK);
    wr(CN, 8'hFE, OK);
    CPU.pulse(3);
    rd(CN, 8'hFD, OK);
    wr(CT, 8'h17, OK);
    wr(CM, 8'h05, OK);
    wr(CN, 8'h04, OK);
    CPU.pulse(3);
    rd(CN, 8'h01, OK);
    done("modes");
    wr(CT, 8'hE0, OK);
    chk("cmp_out", 32'h1, {31'h0, cout});
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    chk("cmp_out", 32'h0, {31'h0, cout});
    rd(CT, 8'h00, OK);
    rd(FL, 8'h00, OK);
    done("second reset");
    report_and_stop;
  end
endmodule
